// File: verilog/ersc_pkg.sv
package ersc_pkg;
    // device register offsets
    localparam logic [7:0] OFS_PAY_ACC_STATUS = 8'hcd;
    localparam logic [7:0] OFS_PAY_ACC_CTL = 8'hce;
    localparam logic [7:0] OFS_PAY_ACC_BYTE = 8'hcf;
    localparam logic [7:0] OFS_RX_PAY_CFG = 8'hd0;
    localparam logic [7:0] OFS_RX_PAY_EN = 8'hd1;
    localparam logic [7:0] OFS_SIG_BUF_CFG = 8'hd2;
    localparam logic [7:0] OFS_SIG_ACC_STATUS = 8'hd3;
    localparam logic [7:0] OFS_SIG_ACC_CTL = 8'hd4;
    localparam logic [7:0] OFS_SIG_ACC_BYTE = 8'hd5;
    localparam logic [7:0] OFS_FLAGS_0 = 8'hd6;
    localparam logic [7:0] OFS_FLAGS_1 = 8'hd7;
    localparam logic [7:0] OFS_FLAGS_2 = 8'hd8;
    localparam logic [7:0] OFS_FLAGS_3 = 8'hd9;
    // field positions
    localparam int CFG_SNAP_BIT = 7;
    localparam int CFG_GSIG_BIT = 6;
    localparam int EN_BIT = 0;
    localparam int BUF_FREEZE_BIT = 3;
    localparam int BUF_DBN_BIT = 2;
    localparam int BUF_IRQE_BIT = 1;
    localparam int CTL_RNW_BIT = 7;
    // replacement selections
    localparam logic [2:0] SEL_PER_SLOT = 3'h0;
    localparam logic [2:0] SEL_CODE = 3'h1;
    localparam logic [2:0] SEL_ALAW = 3'h2;
    localparam logic [2:0] SEL_MULAW = 3'h3;
    // framing and timing
    localparam logic [3:0] SNAP_FRAME = 4'h0;
    localparam int BUSY_CYCLES = 2;
    // controller register map (AXI4-Lite byte addresses)
    localparam logic [3:0] HOFS_RAW_CMD = 4'h0;
    localparam logic [3:0] HOFS_IND_CMD = 4'h4;
    localparam logic [3:0] HOFS_STATUS = 4'h8;
    localparam logic [3:0] HOFS_RESULT = 4'hc;
    localparam int RAW_READ_BIT = 16;
    localparam int IND_BANK_BIT = 17;
    localparam int ST_PENDING_BIT = 0;
    localparam int ST_IRQ_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // slots 0 and 16 carry no channel signaling
    function automatic logic sig_slot_ok(input logic [4:0] slot);
        return (slot != 5'h00) && (slot != 5'h10);
    endfunction : sig_slot_ok

    function automatic logic sig_entry_ok(input logic [6:0] a);
        return (a[6:5] == 2'h0) && sig_slot_ok(a[4:0]);
    endfunction : sig_entry_ok

    // 00-3F per-slot data entries, 41-4F and 51-5F signaling code entries
    function automatic logic pay_entry_ok(input logic [6:0] a);
        return (a[6] == 1'b0) || ((a[6:5] == 2'h2) && sig_slot_ok(a[4:0]));
    endfunction : pay_entry_ok

    function automatic logic [4:0] flag_bit(input logic [4:0] slot);
        return (slot < 5'h10) ? slot - 5'h01 : slot - 5'h02;
    endfunction : flag_bit
endpackage : ersc_pkg

// File: verilog/ersc_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ersc_reg_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic sig_irq;
    modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd, output reg_rdata, sig_irq);
    modport host (output reg_addr, reg_wdata, reg_wr, reg_rd, input reg_rdata, sig_irq);
endinterface : ersc_reg_if
`default_nettype wire

// File: verilog/ersc_device.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ersc_device #(
    parameter int BUSY_CYCLES = ersc_pkg::BUSY_CYCLES,
    parameter logic [63:0] ALAW_MW_PATTERN = 64'h0000_0000_0000_0000,
    parameter logic [63:0] MULAW_MW_PATTERN = 64'h0000_0000_0000_0000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register port
    ersc_reg_if.dev regs,
    // received timeslot stream
    input wire logic rx_valid,
    input wire logic [4:0] rx_slot,
    input wire logic [3:0] rx_frame,
    input wire logic [7:0] rx_data,
    input wire logic [3:0] rx_abcd,
    input wire logic mf_sync,
    // conditioned stream
    output logic out_valid,
    output logic [4:0] out_slot,
    output logic [7:0] out_data,
    output logic [3:0] rx_signaling_out
);
    if (BUSY_CYCLES < 1 || BUSY_CYCLES > 3) begin : g_bad_busy
        $error("BUSY_CYCLES must be 1 to 3");
    end

    typedef struct packed {
        logic snap_en;
        logic gsig_en;
        logic [2:0] gsel;
        logic pay_en;
        logic freeze;
        logic dbn;
        logic irqe;
        logic [7:0] sctl;
        logic [7:0] sbyte;
        logic [7:0] pctl;
        logic [7:0] pbyte;
        logic [1:0] busy_cnt;
        logic busy_pay;
        logic [31:0][2:0] slsel;
        logic [31:0][7:0] dcod;
        logic [31:0][4:0] scode;
        logic [31:0][3:0] abcd;
        logic [31:0][3:0] last;
        logic [31:0][3:0] snap;
        logic [29:0] flags;
        logic [2:0] phase;
        logic [7:0] rdata;
        logic irq;
        logic ovalid;
        logic [4:0] oslot;
        logic [7:0] odata;
        logic [3:0] osig;
    } ersc_dev_state_type;

    ersc_dev_state_type s;
    ersc_dev_state_type n;
    logic [29:0] clr;
    logic [29:0] set;
    logic [7:0] d;
    logic [3:0] sg;
    logic [6:0] ia;
    logic busy;

    function automatic logic [7:0] mw_byte(input logic [63:0] pat, input logic [2:0] ph);
        return pat[{ph, 3'h0} +: 8];
    endfunction : mw_byte

    assign busy = (s.busy_cnt != 2'h0);

    always_comb begin
        n = s;
        clr = '0;
        set = '0;
        d = rx_data;
        sg = rx_abcd;
        ia = 7'h00;
        n.ovalid = rx_valid;
        n.oslot = rx_slot;
        if (regs.reg_wr) begin
            case (regs.reg_addr)
                ersc_pkg::OFS_RX_PAY_CFG: begin
                    n.snap_en = regs.reg_wdata[ersc_pkg::CFG_SNAP_BIT];
                    n.gsig_en = regs.reg_wdata[ersc_pkg::CFG_GSIG_BIT];
                    n.gsel = regs.reg_wdata[2:0];
                end
                ersc_pkg::OFS_RX_PAY_EN: n.pay_en = regs.reg_wdata[ersc_pkg::EN_BIT];
                ersc_pkg::OFS_SIG_BUF_CFG: begin
                    n.freeze = regs.reg_wdata[ersc_pkg::BUF_FREEZE_BIT];
                    n.dbn = regs.reg_wdata[ersc_pkg::BUF_DBN_BIT];
                    n.irqe = regs.reg_wdata[ersc_pkg::BUF_IRQE_BIT];
                end
                // commands and bytes are ignored while an access is under way
                ersc_pkg::OFS_SIG_ACC_CTL: if (!busy) begin
                    n.sctl = regs.reg_wdata;
                    n.busy_pay = 1'b0;
                    n.busy_cnt = 2'(BUSY_CYCLES);
                end
                ersc_pkg::OFS_SIG_ACC_BYTE: if (!busy) n.sbyte = regs.reg_wdata;
                ersc_pkg::OFS_PAY_ACC_CTL: if (!busy) begin
                    n.pctl = regs.reg_wdata;
                    n.busy_pay = 1'b1;
                    n.busy_cnt = 2'(BUSY_CYCLES);
                end
                ersc_pkg::OFS_PAY_ACC_BYTE: if (!busy) n.pbyte = regs.reg_wdata;
                ersc_pkg::OFS_FLAGS_0: clr[7:0] = regs.reg_wdata;
                ersc_pkg::OFS_FLAGS_1: clr[15:8] = regs.reg_wdata;
                ersc_pkg::OFS_FLAGS_2: clr[23:16] = regs.reg_wdata;
                ersc_pkg::OFS_FLAGS_3: clr[29:24] = regs.reg_wdata[5:0];
                default: ;
            endcase
        end
        // indirect access completes on the last busy cycle
        if (busy) begin
            n.busy_cnt = s.busy_cnt - 2'h1;
            if (s.busy_cnt == 2'h1) begin
                if (!s.busy_pay) begin
                    ia = s.sctl[6:0];
                    if (ersc_pkg::sig_entry_ok(ia)) begin
                        if (s.sctl[ersc_pkg::CTL_RNW_BIT]) begin
                            n.sbyte = {4'h0, s.abcd[ia[4:0]]};
                        end else begin
                            n.abcd[ia[4:0]] = s.sbyte[3:0];
                        end
                    end
                end else begin
                    ia = s.pctl[6:0];
                    if (ersc_pkg::pay_entry_ok(ia)) begin
                        case ({ia[6:5], s.pctl[ersc_pkg::CTL_RNW_BIT]})
                            3'h0: n.slsel[ia[4:0]] = s.pbyte[7:5];
                            3'h1: n.pbyte = {s.slsel[ia[4:0]], 5'h00};
                            3'h2: n.dcod[ia[4:0]] = s.pbyte;
                            3'h3: n.pbyte = s.dcod[ia[4:0]];
                            3'h4: n.scode[ia[4:0]] = s.pbyte[4:0];
                            3'h5: n.pbyte = {3'h0, s.scode[ia[4:0]]};
                            default: ;
                        endcase
                    end
                end
            end
        end
        if (rx_valid) begin
            if (rx_slot == 5'h00) begin
                n.phase = s.phase + 3'h1;
            end
            if (ersc_pkg::sig_slot_ok(rx_slot)) begin
                n.last[rx_slot] = rx_abcd;
                if (!s.freeze
                    && (!s.dbn || rx_abcd == s.last[rx_slot])
                    && rx_abcd != s.abcd[rx_slot]) begin
                    n.abcd[rx_slot] = rx_abcd;
                    set[ersc_pkg::flag_bit(rx_slot)] = 1'b1;
                end
            end
            if (rx_frame == ersc_pkg::SNAP_FRAME) begin
                n.snap[rx_slot] = rx_abcd;
            end
            if (s.pay_en) begin
                if (s.snap_en && mf_sync && rx_frame != ersc_pkg::SNAP_FRAME) begin
                    sg = s.snap[rx_slot];
                end
                if (s.gsig_en || s.scode[rx_slot][4]) begin
                    sg = s.scode[rx_slot][3:0];
                end
                case (s.gsel)
                    ersc_pkg::SEL_PER_SLOT: begin
                        case (s.slsel[rx_slot])
                            ersc_pkg::SEL_CODE: d = s.dcod[rx_slot];
                            ersc_pkg::SEL_ALAW: d = mw_byte(ALAW_MW_PATTERN, s.phase);
                            ersc_pkg::SEL_MULAW: d = mw_byte(MULAW_MW_PATTERN, s.phase);
                            default: ;
                        endcase
                    end
                    ersc_pkg::SEL_CODE: d = s.dcod[rx_slot];
                    ersc_pkg::SEL_ALAW: d = mw_byte(ALAW_MW_PATTERN, s.phase);
                    ersc_pkg::SEL_MULAW: d = mw_byte(MULAW_MW_PATTERN, s.phase);
                    default: ;
                endcase
            end
            n.odata = d;
            n.osig = sg;
        end
        // a change in the clearing cycle keeps its flag
        n.flags = (s.flags & ~clr) | set;
        n.irq = n.irqe && (n.flags != 30'h0000_0000);
        if (regs.reg_rd) begin
            case (regs.reg_addr)
                ersc_pkg::OFS_PAY_ACC_STATUS: n.rdata = {7'h00, busy && s.busy_pay};
                ersc_pkg::OFS_PAY_ACC_CTL: n.rdata = s.pctl;
                ersc_pkg::OFS_PAY_ACC_BYTE: n.rdata = s.pbyte;
                ersc_pkg::OFS_RX_PAY_CFG: n.rdata = {s.snap_en, s.gsig_en, 3'h0, s.gsel};
                ersc_pkg::OFS_RX_PAY_EN: n.rdata = {7'h00, s.pay_en};
                ersc_pkg::OFS_SIG_BUF_CFG: n.rdata = {4'h0, s.freeze, s.dbn, s.irqe, 1'b0};
                ersc_pkg::OFS_SIG_ACC_STATUS: n.rdata = {7'h00, busy && !s.busy_pay};
                ersc_pkg::OFS_SIG_ACC_CTL: n.rdata = s.sctl;
                ersc_pkg::OFS_SIG_ACC_BYTE: n.rdata = s.sbyte;
                ersc_pkg::OFS_FLAGS_0: n.rdata = s.flags[7:0];
                ersc_pkg::OFS_FLAGS_1: n.rdata = s.flags[15:8];
                ersc_pkg::OFS_FLAGS_2: n.rdata = s.flags[23:16];
                ersc_pkg::OFS_FLAGS_3: n.rdata = {2'h0, s.flags[29:24]};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign regs.reg_rdata = s.rdata;
    assign regs.sig_irq = s.irq;
    assign out_valid = s.ovalid;
    assign out_slot = s.oslot;
    assign out_data = s.odata;
    assign rx_signaling_out = s.osig;
endmodule : ersc_device
`default_nettype wire

// File: verilog/ersc_host.sv
`timescale 1ns/1ns
`default_nettype none
module ersc_host #(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device register port
    ersc_reg_if.host regs
);
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must be 4 to 32");
    end

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_RAW = 3'h1,
        H_POLL1 = 3'h2,
        H_WDATA = 3'h3,
        H_WCTRL = 3'h4,
        H_POLL2 = 3'h5,
        H_GET = 3'h6
    } ersc_host_phase_type;

    typedef struct packed {
        ersc_host_phase_type st;
        logic [1:0] p;
        logic bank;
        logic rnw;
        logic [6:0] iaddr;
        logic [7:0] ibyte;
        logic [7:0] result;
        logic refused;
        logic [7:0] raddr;
        logic [7:0] rwdata;
        logic rwr;
        logic rrd;
        logic aw_got;
        logic [ADDR_W-1:0] awa;
        logic w_got;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ersc_host_state_type;

    ersc_host_state_type s;
    ersc_host_state_type n;
    logic [7:0] ofs_stat;
    logic [7:0] ofs_ctl;
    logic [7:0] ofs_byte;
    logic [7:0] rd_target;

    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready = !s.w_got && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign ofs_stat = s.bank ? ersc_pkg::OFS_PAY_ACC_STATUS : ersc_pkg::OFS_SIG_ACC_STATUS;
    assign ofs_ctl = s.bank ? ersc_pkg::OFS_PAY_ACC_CTL : ersc_pkg::OFS_SIG_ACC_CTL;
    assign ofs_byte = s.bank ? ersc_pkg::OFS_PAY_ACC_BYTE : ersc_pkg::OFS_SIG_ACC_BYTE;
    assign rd_target = (s.st == H_RAW) ? s.raddr : ((s.st == H_GET) ? ofs_byte : ofs_stat);

    always_comb begin
        n = s;
        n.rwr = 1'b0;
        n.rrd = 1'b0;
        case (s.st)
            H_RAW, H_POLL1, H_POLL2, H_GET: begin
                // strobe, wait, then sample the registered answer
                if (s.p == 2'h0) begin
                    n.rrd = 1'b1;
                    n.raddr = rd_target;
                    n.p = 2'h1;
                end else if (s.p == 2'h1) begin
                    n.p = 2'h2;
                end else begin
                    n.p = 2'h0;
                    if (s.st == H_POLL1) begin
                        if (!regs.reg_rdata[0]) begin
                            n.st = s.rnw ? H_WCTRL : H_WDATA;
                        end
                    end else if (s.st == H_POLL2) begin
                        if (!regs.reg_rdata[0]) begin
                            n.st = s.rnw ? H_GET : H_IDLE;
                        end
                    end else begin
                        n.result = regs.reg_rdata;
                        n.st = H_IDLE;
                    end
                end
            end
            H_WDATA: begin
                n.rwr = 1'b1;
                n.raddr = ofs_byte;
                n.rwdata = s.ibyte;
                n.st = H_WCTRL;
            end
            H_WCTRL: begin
                n.rwr = 1'b1;
                n.raddr = ofs_ctl;
                n.rwdata = {s.rnw, s.iaddr};
                n.st = H_POLL2;
            end
            default: ;
        endcase
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wd = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = ersc_pkg::RESP_OKAY;
            if ((s.awa >> 4) != '0) begin
                n.bresp = ersc_pkg::RESP_SLVERR;
            end else if (s.awa[3:0] == ersc_pkg::HOFS_RAW_CMD && s.st == H_IDLE) begin
                n.raddr = s.wd[7:0];
                n.rwdata = s.wd[15:8];
                n.refused = s.wd[7:0] == ersc_pkg::OFS_RX_PAY_CFG
                    && s.wd[10] && !s.wd[ersc_pkg::RAW_READ_BIT];
                if (s.wd[ersc_pkg::RAW_READ_BIT]) begin
                    n.st = H_RAW;
                    n.p = 2'h0;
                end else begin
                    n.rwr = !n.refused;
                end
            end else if (s.awa[3:0] == ersc_pkg::HOFS_IND_CMD && s.st == H_IDLE) begin
                n.bank = s.wd[ersc_pkg::IND_BANK_BIT];
                n.rnw = s.wd[ersc_pkg::CTL_RNW_BIT];
                n.iaddr = s.wd[6:0];
                n.ibyte = s.wd[15:8];
                n.refused = n.bank ? !ersc_pkg::pay_entry_ok(s.wd[6:0])
                                   : !ersc_pkg::sig_entry_ok(s.wd[6:0]);
                n.st = n.refused ? H_IDLE : H_POLL1;
                n.p = 2'h0;
            end else if (s.awa[3:0] != ersc_pkg::HOFS_RAW_CMD
                         && s.awa[3:0] != ersc_pkg::HOFS_IND_CMD) begin
                n.bresp = ersc_pkg::RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp = ersc_pkg::RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if ((s_axi_araddr >> 4) != '0) begin
                n.rresp = ersc_pkg::RESP_SLVERR;
            end else begin
                case (s_axi_araddr[3:0])
                    ersc_pkg::HOFS_STATUS: begin
                        n.rdata[ersc_pkg::ST_PENDING_BIT] = (s.st != H_IDLE);
                        n.rdata[ersc_pkg::ST_IRQ_BIT] = regs.sig_irq;
                        n.rdata[ersc_pkg::ST_REFUSED_BIT] = s.refused;
                    end
                    ersc_pkg::HOFS_RESULT: n.rdata[7:0] = s.result;
                    ersc_pkg::HOFS_RAW_CMD, ersc_pkg::HOFS_IND_CMD: ;
                    default: n.rresp = ersc_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign regs.reg_addr = s.raddr;
    assign regs.reg_wdata = s.rwdata;
    assign regs.reg_wr = s.rwr;
    assign regs.reg_rd = s.rrd;
endmodule : ersc_host
`default_nettype wire

// File: bench/ersc_props.sv
`timescale 1ns/1ns
`default_nettype none
module ersc_props #(
    parameter int BUSY_CYCLES = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sig_irq
);
    logic [3:0] bcnt;
    logic irqe;
    logic loaded;
    wire logic ctl = reg_wr && reg_addr == 8'hd4;
    wire logic rd3 = reg_rd && reg_addr == 8'hd3;
    // mirror of busy window, irq enable and byte-loaded state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcnt <= 4'h0;
            irqe <= 1'b0;
            loaded <= 1'b0;
        end else begin
            if (ctl && bcnt == 4'h0) begin
                bcnt <= 4'(BUSY_CYCLES);
            end else if (bcnt != 4'h0) begin
                bcnt <= bcnt - 4'h1;
            end
            if (reg_wr && reg_addr == 8'hd2) begin
                irqe <= reg_wdata[1];
            end
            if (reg_wr && reg_addr == 8'hd5) begin
                loaded <= 1'b1;
            end else if (ctl) begin
                loaded <= 1'b0;
            end
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_busy_high: assert property (rd3 && bcnt != 0 |=> reg_rdata == 8'h01)
        else $error("busy not shown");
    a_busy_low: assert property (rd3 && bcnt == 0 |=> reg_rdata == 8'h00)
        else $error("busy stuck");
    a_irq_gate: assert property (sig_irq |-> irqe)
        else $error("irq while disabled");
    a_byte_first: assert property (ctl && !reg_wdata[7] |-> loaded)
        else $error("write command without byte");
    a_host_waits: assert property (ctl |-> bcnt == 0)
        else $error("command while busy");
    a_read_after: assert property (reg_rd && reg_addr == 8'hd5 |-> bcnt == 0)
        else $error("byte read while busy");
    a_flags_top: assert property (reg_rd && reg_addr == 8'hd9 |=> reg_rdata[7:6] == 2'h0)
        else $error("unused flag bits set");
    a_entry_valid: assert property (ctl |-> reg_wdata[6:5] == 2'h0 && reg_wdata[3:0] != 0)
        else $error("bad indirect entry");
endmodule : ersc_props
`default_nettype wire

// File: bench/e1_rx_payload_signaling_ctl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module e1_rx_payload_signaling_ctl_tb;
    localparam logic [8:0] P9 = 9'h100;
    localparam logic [4:0] P5 = 5'h10;
    logic aclk = 0, aresetn = 0, mf_sync = 0, rx_valid = 0, out_valid;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0, rx_frame = 0, rx_abcd = 0, out_sig;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [4:0] rx_slot = 0, out_slot;
    logic [7:0] rx_data = 0, out_data;
    logic [16:0] expq[$];
    int seed = 32'haca09694, compares = 0, miscompares = 0;
    ersc_reg_if rif();
    ersc_host ersc_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .regs(rif.host));
    ersc_device #(.ALAW_MW_PATTERN({8{8'h5a}}), .MULAW_MW_PATTERN({8{8'ha5}})) ersc_device_i (
        .aclk(aclk), .aresetn(aresetn), .regs(rif.dev), .rx_valid(rx_valid),
        .rx_slot(rx_slot), .rx_frame(rx_frame), .rx_data(rx_data), .rx_abcd(rx_abcd),
        .mf_sync(mf_sync), .out_valid(out_valid), .out_slot(out_slot),
        .out_data(out_data), .rx_signaling_out(out_sig));
    ersc_props #(.BUSY_CYCLES(ersc_pkg::BUSY_CYCLES)) ersc_props_i (.aclk(aclk),
        .aresetn(aresetn), .reg_addr(rif.reg_addr), .reg_wdata(rif.reg_wdata),
        .reg_wr(rif.reg_wr), .reg_rd(rif.reg_rd), .reg_rdata(rif.reg_rdata),
        .sig_irq(rif.sig_irq));
    always #2 aclk = ~aclk;
    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [16:0] g, input logic [16:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // handshakes are judged on the values seen at the rising edge itself
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic b;
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        b = 0;
        while (!b) begin
            @(posedge aclk);
            b = bvalid;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        bready <= 0;
        @(posedge aclk);
    endtask : axw
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        logic r;
        {araddr, arvalid, rready} <= {a, 2'b11};
        r = 0;
        while (!r) begin
            @(posedge aclk);
            {r, d} = {rvalid, rdata};
            if (arready) arvalid <= 0;
        end
        rready <= 0;
        @(posedge aclk);
    endtask : axr
    task automatic raw(input logic [7:0] o, input logic [7:0] v, input logic rd);
        logic [31:0] s;
        axw(4'h0, {15'h0, rd, v, o});
        do axr(4'h8, s); while (s[0]);
    endtask : raw
    task automatic ind(input logic [6:0] e, input logic [7:0] v, input logic rd, input logic bk);
        logic [31:0] s;
        axw(4'h4, {14'h0, bk, 1'b0, v, rd, e});
        do axr(4'h8, s); while (s[0]);
    endtask : ind
    task automatic rchk(input logic [7:0] o, input logic [7:0] e);
        logic [31:0] s;
        raw(o, 8'h00, 1);
        axr(4'hc, s);
        cmp({9'h0, s[7:0]}, {9'h0, e});
    endtask : rchk
    task automatic ichk(input logic [6:0] a, input logic [7:0] e);
        logic [31:0] s;
        ind(a, 8'h00, 1, 0);
        axr(4'hc, s);
        cmp({9'h0, s[7:0]}, {9'h0, e});
    endtask : ichk
    task automatic stat(input logic [2:0] e);
        logic [31:0] s;
        axr(4'h8, s);
        cmp({14'h0, s[2:0]}, {14'h0, e});
    endtask : stat
    task automatic slot(input logic [4:0] n, input logic [3:0] f, input logic [3:0] a,
        input logic [8:0] ed, input logic [4:0] es);
        logic [7:0] d;
        d = 8'($random(seed));
        {rx_valid, rx_slot, rx_frame, rx_abcd, rx_data} <= {1'b1, n, f, a, d};
        expq.push_back({ed[8] ? d : ed[7:0], n, es[4] ? a : es[3:0]});
        @(posedge aclk);
        rx_valid <= 0;
        @(posedge aclk);
    endtask : slot
    always @(negedge aclk) begin
        if (out_valid === 1'b1) cmp({out_data, out_slot, out_sig}, expq.pop_front());
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rchk(8'hd0, 8'h00);
        raw(8'hd2, 8'h02, 0);
        slot(5'd3, 0, 4'h9, P9, P5);
        slot(5'd15, 0, 4'h1, P9, P5);
        slot(5'd16, 0, 4'h7, P9, P5);
        slot(5'd17, 0, 4'h5, P9, P5);
        slot(5'd31, 0, 4'h1, P9, P5);
        rchk(8'hd6, 8'h04);
        rchk(8'hd7, 8'hc0);
        rchk(8'hd9, 8'h20);
        stat(3'h2);
        raw(8'hd6, 8'hfb, 0);
        rchk(8'hd6, 8'h04);
        raw(8'hd6, 8'h04, 0);
        rchk(8'hd6, 8'h00);
        raw(8'hd2, 8'h00, 0);
        stat(3'h0);
        ichk(7'h11, 8'h05);
        ind(7'h11, 8'h0a, 0, 0);
        ichk(7'h11, 8'h0a);
        raw(8'hd2, 8'h08, 0);
        slot(5'd3, 0, 4'h3, P9, P5);
        ichk(7'h03, 8'h09);
        raw(8'hd2, 8'h04, 0);
        slot(5'd3, 0, 4'hc, P9, P5);
        ichk(7'h03, 8'h09);
        slot(5'd3, 0, 4'hc, P9, P5);
        ichk(7'h03, 8'h0c);
        raw(8'hd1, 8'h01, 0);
        ind(7'h27, 8'h3c, 0, 1);
        ind(7'h07, 8'h20, 0, 1);
        ind(7'h47, 8'h1b, 0, 1);
        ind(7'h48, 8'h0d, 0, 1);
        raw(8'hd0, 8'h01, 0);
        slot(5'd7, 0, 4'h2, 9'h03c, 5'h0b);
        for (int i = 2; i < 4; i++) begin
            raw(8'hd0, 8'(i), 0);
            slot(5'd8, 0, 4'h2, i == 2 ? 9'h05a : 9'h0a5, P5);
        end
        raw(8'hd0, 8'h00, 0);
        slot(5'd7, 0, 4'h2, 9'h03c, 5'h0b);
        slot(5'd8, 0, 4'h2, P9, P5);
        raw(8'hd0, 8'h40, 0);
        slot(5'd8, 0, 4'h2, P9, 5'h0d);
        raw(8'hd0, 8'h80, 0);
        mf_sync <= 1;
        slot(5'd9, 0, 4'h6, P9, 5'h06);
        slot(5'd9, 4'h3, 4'h2, P9, 5'h06);
        raw(8'hd0, 8'h41, 0);
        raw(8'hd1, 8'h00, 0);
        slot(5'd7, 0, 4'h2, P9, P5);
        raw(8'hd0, 8'h04, 0);
        stat(3'h4);
        ind(7'h10, 8'h00, 1, 0);
        stat(3'h4);
        print_verdict();
    end
endmodule : e1_rx_payload_signaling_ctl_tb
`default_nettype wire
